// *** pkg/sysref_status_pkg.sv ***
// Purpose: Constants for the SYSREF control, input re-validation and status register bank.
// Assumes: One core clock at 100 MHz; 7-bit register addresses with 8-bit data.
// Notes: Offsets, register reset values and single-bit field positions live here; multi-bit fields are sliced in the module.
package sysref_status_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam logic [6:0] ADDR_SEL_MODE = 7'h15;
    localparam logic [6:0] ADDR_INPUT_CTRL = 7'h17;
    localparam logic [6:0] ADDR_SR_DIV = 7'h18;
    localparam logic [6:0] ADDR_SR_PWR = 7'h19;
    localparam logic [6:0] ADDR_SR_COUNT = 7'h1A;
    localparam logic [6:0] ADDR_SR_DELAY = 7'h1B;
    localparam logic [6:0] ADDR_SR_MODE = 7'h1C;
    localparam logic [6:0] ADDR_LOCK_CTRL = 7'h1F;
    localparam logic [6:0] ADDR_IE_LOCK = 7'h68;
    localparam logic [6:0] ADDR_REFERENCE_IRQ_EN = 7'h69;
    localparam logic [6:0] ADDR_LS_LOCK = 7'h6C;
    localparam logic [6:0] ADDR_ST_LOCK = 7'h6D;
    localparam logic [6:0] ADDR_REFERENCE_VALID_LATCHED = 7'h6E;
    localparam logic [6:0] ADDR_ST_REF = 7'h6F;
    localparam logic [6:0] ADDR_START = 7'h70;
    localparam logic [7:0] RST_SEL_MODE = 8'h00;
    localparam logic [7:0] RST_INPUT_CTRL = 8'h82;
    localparam logic [7:0] RST_SR_DIV = 8'h00;
    localparam logic [7:0] RST_SR_PWR = 8'h51;
    localparam logic [7:0] RST_SR_COUNT = 8'h02;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_LATCH_LOCK = 8'h3F;
    localparam logic [7:0] RST_LATCH_REF = 8'h03;
    localparam logic [7:0] OSC_KEY = 8'h4B;
    localparam int BIT_REF_LOSS_BLOCK = 6;
    localparam int BIT_PREDIV = 5;
    localparam int BIT_SR_PD = 7;
    localparam int BIT_BIAS = 6;
    localparam int BIT_INSEL = 2;
    localparam int BIT_SRC = 1;
    localparam int BIT_MODE = 0;
    localparam int BIT_BLOCK_LOLV = 7;
    localparam int BIT_START = 7;
    localparam int DIVSEL_W = 2;
    localparam logic [1:0] HOLDOFF_2P15 = 2'h0;
    localparam logic [1:0] HOLDOFF_2P16 = 2'h1;
    localparam int HOLDOFF_W = 17;
    localparam int REVAL_W = 8;
    localparam logic [7:0] REVAL_CNT_0 = 8'h08;
    localparam logic [7:0] REVAL_CNT_1 = 8'h10;
    localparam logic [7:0] REVAL_CNT_2 = 8'h20;
    localparam logic [7:0] REVAL_CNT_3 = 8'h40;
    localparam logic [1:0] PREDIV_LAST = 2'h3;
    localparam int RATIO_W = 15;
    localparam logic [5:0] SYNC_MIN_LEGAL = 6'h02;
    localparam int DELAY_STEP_PS = 543;
    localparam int NUM_INPUTS = 4;
    typedef enum logic [2:0] {
        GEN_IDLE = 3'b001,
        GEN_ARM = 3'b010,
        GEN_RUN = 3'b100
    } gen_state_t;
endpackage

// *** src/sysref_status_control_regs.sv ***
// Purpose: SYSREF pulse generator control, input re-validation, hold-off tick and status registers.
// Assumes: Monitor, selection and PLL status inputs are on core_clk; pins pass a 3-stage filter.
// Notes: Register access comes from the serial port front end as address, data and strobes.
`timescale 1ns/1ps
module sysref_status_control_regs
    import sysref_status_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic [NUM_INPUTS-1:0] input_los_event,
    input wire logic [NUM_INPUTS-1:0] input_period_valid,
    input wire logic [NUM_INPUTS-1:0] input_edge_missing,
    input wire logic [1:0] selected_input_status,
    input wire logic synth_lol,
    input wire logic osc_loop_lol,
    input wire logic reference_present,
    input wire logic holdover_active,
    input wire logic synth_calibrating,
    input wire logic coincident_edge,
    input wire logic external_sysref_pin,
    input wire logic clk3_sysref_in,
    input wire logic output_bias_request_n,
    input wire logic osc_out_power,
    input wire logic osc_out_style,
    input wire logic [1:0] osc_out_amplitude,
    output logic [NUM_INPUTS-1:0] input_power_down,
    output logic [NUM_INPUTS-1:0] input_los_flag,
    output logic holdoff_tick,
    output logic lock_out,
    output logic irq_out_n,
    output logic sysref_powered,
    output logic sysref_pulse,
    output logic sysref_bias_xpoint,
    output logic sysref_bias_active,
    output logic sysref_phase_align,
    output logic [7:0] sysref_delay_steps,
    output logic [5:0] sysref_sync_code,
    output logic osc_eff_power,
    output logic osc_eff_style,
    output logic [1:0] osc_eff_amplitude
);

    // Software registers.
    logic [7:0] sel_mode_reg;
    logic [7:0] input_ctrl_reg;
    logic [7:0] sr_div_reg;
    logic [7:0] sr_pwr_reg;
    logic [7:0] sr_count_reg;
    logic [7:0] sr_delay_reg;
    logic [7:0] sr_mode_reg;
    logic [7:0] lock_ctrl_reg;
    logic [7:0] ie_lock_reg;
    logic [7:0] reference_irq_en_reg;
    logic [5:0] ls_lock_reg;
    logic [1:0] reference_valid_latched_reg;
    // Write strobes come from one decode so every register sees the same address compare.
    wire wr_sel_mode = reg_wr && (reg_addr == ADDR_SEL_MODE);
    wire wr_input_ctrl = reg_wr && (reg_addr == ADDR_INPUT_CTRL);
    wire wr_sr_div = reg_wr && (reg_addr == ADDR_SR_DIV);
    wire wr_sr_pwr = reg_wr && (reg_addr == ADDR_SR_PWR);
    wire wr_sr_count = reg_wr && (reg_addr == ADDR_SR_COUNT);
    wire wr_sr_delay = reg_wr && (reg_addr == ADDR_SR_DELAY);
    wire wr_sr_mode = reg_wr && (reg_addr == ADDR_SR_MODE);
    wire wr_lock_ctrl = reg_wr && (reg_addr == ADDR_LOCK_CTRL);
    wire wr_ie_lock = reg_wr && (reg_addr == ADDR_IE_LOCK);
    wire wr_reference_irq_en = reg_wr && (reg_addr == ADDR_REFERENCE_IRQ_EN);
    wire wr_ls_lock = reg_wr && (reg_addr == ADDR_LS_LOCK);
    wire wr_reference_valid_latched = reg_wr && (reg_addr == ADDR_REFERENCE_VALID_LATCHED);
    wire wr_start = reg_wr && (reg_addr == ADDR_START);
    // Named fields.
    wire ref_loss_block = sel_mode_reg[BIT_REF_LOSS_BLOCK];
    wire revalidation_prediv = sel_mode_reg[BIT_PREDIV];
    wire [1:0] holdoff_ref_divider = input_ctrl_reg[7:6];
    wire [1:0] revalidation_count = input_ctrl_reg[1:0];
    wire sysref_power_down = sr_pwr_reg[BIT_SR_PD];
    wire sysref_bias_type = sr_pwr_reg[BIT_BIAS];
    wire [5:0] sync_code = sr_pwr_reg[5:0];
    wire sysref_input_sel = sr_mode_reg[BIT_INSEL];
    wire sysref_source_sel = sr_mode_reg[BIT_SRC];
    wire sysref_pulse_mode = sr_mode_reg[BIT_MODE];
    wire block_osc_lock = lock_ctrl_reg[BIT_BLOCK_LOLV];
    wire [7:0] osc_out_mod_key = {sr_mode_reg[7:4], lock_ctrl_reg[3:0]};
    // Plain control registers; the key halves and mode bits share their bytes with other fields.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sel_mode_reg <= RST_SEL_MODE;
            input_ctrl_reg <= RST_INPUT_CTRL;
            sr_div_reg <= RST_SR_DIV;
            sr_count_reg <= RST_SR_COUNT;
            sr_delay_reg <= RST_ZERO;
            sr_mode_reg <= RST_ZERO;
            lock_ctrl_reg <= RST_ZERO;
            ie_lock_reg <= RST_ZERO;
            reference_irq_en_reg <= RST_ZERO;
        end else if (clk_en) begin
            if (wr_sel_mode) sel_mode_reg <= {1'b0, reg_wdata[6:0]};
            if (wr_input_ctrl) input_ctrl_reg <= reg_wdata;
            if (wr_sr_div) sr_div_reg <= reg_wdata;
            if (wr_sr_count) sr_count_reg <= reg_wdata;
            if (wr_sr_delay) sr_delay_reg <= reg_wdata;
            if (wr_sr_mode) sr_mode_reg <= {reg_wdata[7:4], 1'b0, reg_wdata[2:0]};
            if (wr_lock_ctrl) lock_ctrl_reg <= reg_wdata;
            if (wr_ie_lock) ie_lock_reg <= {2'b00, reg_wdata[5:0]};
            if (wr_reference_irq_en) reference_irq_en_reg <= {6'b000000, reg_wdata[1:0]};
        end
    end

    // Start is honoured only with internal generation selected.
    // start gating
    wire start_req = wr_start && reg_wdata[BIT_START] && !sysref_source_sel;
    // Power byte: a start clears the power-down bit because it powers the SYSREF circuitry up.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sr_pwr_reg <= RST_SR_PWR;
        end else if (clk_en) begin
            if (wr_sr_pwr) begin
                sr_pwr_reg <= reg_wdata;
            end else if (start_req) begin
                sr_pwr_reg[BIT_SR_PD] <= 1'b0;
            end
        end
    end

    // Pin inputs: three stages, a change is taken once stages two and three agree.
    logic [2:0] ext_sync;
    logic [2:0] clk3_sync;
    logic [2:0] bias_sync;
    logic ext_filt;
    logic clk3_filt;
    logic bias_req_n_filt;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_sync <= 3'h0;
            clk3_sync <= 3'h0;
            bias_sync <= 3'h7;
            ext_filt <= 1'b0;
            clk3_filt <= 1'b0;
            bias_req_n_filt <= 1'b1;
        end else if (clk_en) begin
            ext_sync <= {ext_sync[1:0], external_sysref_pin};
            clk3_sync <= {clk3_sync[1:0], clk3_sysref_in};
            bias_sync <= {bias_sync[1:0], output_bias_request_n};
            if (ext_sync[1] == ext_sync[2]) ext_filt <= ext_sync[2];
            if (clk3_sync[1] == clk3_sync[2]) clk3_filt <= clk3_sync[2];
            if (bias_sync[1] == bias_sync[2]) bias_req_n_filt <= bias_sync[2];
        end
    end

    wire ext_trig_level = sysref_input_sel ? clk3_filt : ext_filt;
    logic ext_trig_d;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_trig_d <= 1'b0;
        end else if (clk_en) begin
            ext_trig_d <= ext_trig_level;
        end
    end
    wire ext_start = sysref_source_sel && ext_trig_level && !ext_trig_d;

    // Hold-off reference divider; code 11 is undefined and treated as the longest division.
    logic [HOLDOFF_W-1:0] holdoff_cnt;
    wire holdoff_wrap = (holdoff_ref_divider == HOLDOFF_2P15) ? (&holdoff_cnt[HOLDOFF_W-3:0]) :
                        (holdoff_ref_divider == HOLDOFF_2P16) ? (&holdoff_cnt[HOLDOFF_W-2:0]) :
                        (&holdoff_cnt);
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            holdoff_cnt <= '0;
            holdoff_tick <= 1'b0;
        end else if (clk_en) begin
            holdoff_cnt <= holdoff_wrap ? '0 : holdoff_cnt + 1'b1;
            holdoff_tick <= holdoff_wrap;
        end
    end

    // Re-validation count selected by the two-bit field.
    wire [REVAL_W-1:0] reval_load = (revalidation_count == 2'h0) ? REVAL_CNT_0 :
                                    (revalidation_count == 2'h1) ? REVAL_CNT_1 :
                                    (revalidation_count == 2'h2) ? REVAL_CNT_2 : REVAL_CNT_3;

    // One re-validation engine per clock input; a powered-down input sees no monitor events.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_reval
            logic [REVAL_W-1:0] reval_cnt;
            logic [1:0] prediv_cnt;
            wire enabled = !input_power_down[gi];
            wire period_tick = enabled && input_period_valid[gi] &&
                               (!revalidation_prediv || (prediv_cnt == PREDIV_LAST));
            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    reval_cnt <= '0;
                    prediv_cnt <= 2'h0;
                    input_los_flag[gi] <= 1'b0;
                end else if (clk_en) begin
                    if (enabled && input_period_valid[gi]) prediv_cnt <= prediv_cnt + 2'h1;
                    if (enabled && (input_los_event[gi] || (input_los_flag[gi] && input_edge_missing[gi]))) begin
                        input_los_flag[gi] <= 1'b1;
                        reval_cnt <= reval_load;
                        prediv_cnt <= 2'h0;
                    end else if (input_los_flag[gi] && period_tick) begin
                        reval_cnt <= reval_cnt - 1'b1;
                        if (reval_cnt <= 8'h01) input_los_flag[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    assign input_power_down = input_ctrl_reg[5:2];
    // Live status. Reference inactivity counts as loop unlock unless blocked.
    // blockable reference loss
    wire osc_loop_loss = osc_loop_lol || (!ref_loss_block && !reference_present);
    wire synth_lock_live_n = !synth_lol;
    wire osc_loop_lock_live_n = !osc_loop_loss;
    wire [3:0] input_ok_live = ~input_los_flag;
    wire [7:0] st_lock_byte = {selected_input_status, synth_lock_live_n, osc_loop_lock_live_n, input_ok_live};
    wire [7:0] st_ref_byte = {5'b00000, synth_calibrating, reference_present, !holdover_active};

    // Lock pin; a loop unlock may be kept off it, and so may reference loss when blocked.
    // lock pin blocking
    wire lock_next = !synth_lol && (block_osc_lock || !osc_loop_lol) && (ref_loss_block || reference_present);

    // Latched flags: a low live bit pulls the latch to 0; a write of 1 returns it to 1.
    // The event wins a clash with the clear so that no loss can slip past unseen.
    wire [5:0] lock_events = ~st_lock_byte[5:0];
    wire [1:0] ref_events = {!reference_present, holdover_active};
    wire [5:0] lock_clear = wr_ls_lock ? reg_wdata[5:0] : 6'h00;
    wire [1:0] ref_clear = wr_reference_valid_latched ? reg_wdata[1:0] : 2'h0;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ls_lock_reg <= RST_LATCH_LOCK[5:0];
            reference_valid_latched_reg <= RST_LATCH_REF[1:0];
        end else if (clk_en) begin
            ls_lock_reg <= (ls_lock_reg | lock_clear) & ~lock_events;
            reference_valid_latched_reg <= (reference_valid_latched_reg | ref_clear) & ~ref_events;
        end
    end
    wire irq_pending = |(~ls_lock_reg & ie_lock_reg[5:0]) || |(~reference_valid_latched_reg & reference_irq_en_reg[1:0]);

    // Status outputs are registered so the pins never glitch on decode.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            lock_out <= 1'b0;
            irq_out_n <= 1'b1;
        end else if (clk_en) begin
            lock_out <= lock_next;
            irq_out_n <= !irq_pending;
        end
    end

    // SYSREF divide ratio: two times the five stage factors.
    // stage product
    wire [4:0] f_76 = 5'h02 << sr_div_reg[7:6];
    wire [2:0] f_54 = {1'b0, sr_div_reg[5:4]} + 3'h2;
    wire [2:0] f_3 = sr_div_reg[3] ? 3'h4 : 3'h2;
    wire [2:0] f_2 = sr_div_reg[2] ? 3'h4 : 3'h2;
    wire [2:0] f_10 = {1'b0, sr_div_reg[1:0]} + 3'h2;
    wire [RATIO_W-1:0] sr_ratio = RATIO_W'(2 * f_76 * f_54 * f_3 * f_2 * f_10);

    // Release codes below the first legal one never free a pulse.
    // coincident release
    wire release_ok = coincident_edge && (sync_code >= SYNC_MIN_LEGAL);

    gen_state_t gen_state_reg;
    gen_state_t gen_state_next;
    logic [RATIO_W-1:0] period_cnt;
    logic [7:0] remaining_reg;
    wire period_start = (gen_state_reg == GEN_RUN) && (period_cnt == '0);
    wire last_pulse = period_start && !sysref_pulse_mode && (remaining_reg <= 8'h01);
    wire trigger = start_req || ext_start;

    // Generator state: armed by a trigger, running from a coincident edge, stopped by power-down.
    always_comb begin
        gen_state_next = gen_state_reg;
        unique case (gen_state_reg)
            GEN_IDLE: begin
                if (trigger && (sysref_pulse_mode || (sr_count_reg != 8'h00))) gen_state_next = GEN_ARM;
            end
            GEN_ARM: begin
                if (release_ok) gen_state_next = GEN_RUN;
            end
            GEN_RUN: begin
                if (last_pulse) gen_state_next = GEN_IDLE;
            end
        endcase
        if (sysref_power_down && !start_req) gen_state_next = GEN_IDLE;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            gen_state_reg <= GEN_IDLE;
            period_cnt <= '0;
            remaining_reg <= 8'h00;
            sysref_pulse <= 1'b0;
        end else if (clk_en) begin
            gen_state_reg <= gen_state_next;
            sysref_pulse <= period_start;
            if (gen_state_reg != GEN_RUN) begin
                period_cnt <= '0;
                remaining_reg <= sr_count_reg;
            end else begin
                period_cnt <= (period_cnt == sr_ratio - 1'b1) ? '0 : period_cnt + 1'b1;
                if (period_start) remaining_reg <= remaining_reg - 8'h01;
            end
        end
    end

    // Start aligns the reference outputs and takes the delay into the path.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sysref_phase_align <= 1'b0;
            sysref_delay_steps <= RST_ZERO;
            sysref_powered <= 1'b0;
            sysref_sync_code <= RST_SR_PWR[5:0];
            sysref_bias_xpoint <= 1'b1;
            sysref_bias_active <= 1'b0;
        end else if (clk_en) begin
            sysref_phase_align <= start_req;
            if (start_req) sysref_delay_steps <= sr_delay_reg;
            sysref_powered <= !sysref_power_down || start_req;
            sysref_sync_code <= sync_code;
            sysref_bias_xpoint <= sysref_bias_type;
            sysref_bias_active <= !bias_req_n_filt || (gen_state_reg != GEN_IDLE);
        end
    end
    // Oscillator output falls back to its startup form unless the key is in place.
    // key check
    wire key_ok = (osc_out_mod_key == OSC_KEY);
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            osc_eff_power <= 1'b1;
            osc_eff_style <= 1'b1;
            osc_eff_amplitude <= 2'h3;
        end else if (clk_en) begin
            osc_eff_power <= key_ok ? osc_out_power : 1'b1;
            osc_eff_style <= key_ok ? osc_out_style : 1'b1;
            osc_eff_amplitude <= key_ok ? osc_out_amplitude : 2'h3;
        end
    end
    // Read mux; unmapped addresses and the start register read as zero.
    logic [7:0] rd_mux;
    always_comb begin
        unique case (reg_addr)
            ADDR_SEL_MODE: rd_mux = sel_mode_reg;
            ADDR_INPUT_CTRL: rd_mux = input_ctrl_reg;
            ADDR_SR_DIV: rd_mux = sr_div_reg;
            ADDR_SR_PWR: rd_mux = sr_pwr_reg;
            ADDR_SR_COUNT: rd_mux = sr_count_reg;
            ADDR_SR_DELAY: rd_mux = sr_delay_reg;
            ADDR_SR_MODE: rd_mux = sr_mode_reg;
            ADDR_LOCK_CTRL: rd_mux = lock_ctrl_reg;
            ADDR_IE_LOCK: rd_mux = ie_lock_reg;
            ADDR_REFERENCE_IRQ_EN: rd_mux = reference_irq_en_reg;
            ADDR_LS_LOCK: rd_mux = {2'b00, ls_lock_reg};
            ADDR_ST_LOCK: rd_mux = st_lock_byte;
            ADDR_REFERENCE_VALID_LATCHED: rd_mux = {6'b000000, reference_valid_latched_reg};
            ADDR_ST_REF: rd_mux = st_ref_byte;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else if (clk_en) begin
            reg_rvalid <= reg_rd;
            if (reg_rd) reg_rdata <= rd_mux;
        end
    end

endmodule

// *** test/sysref_regs_chk_sva.sv ***
// Purpose: Port-level checks of the SYSREF control and status bank.
// Assumes: One clock domain; clk_en stays high while checked.
// Notes: A shadow of the source bit tells a taken start from a refused one.
`timescale 1ns/1ps
module sysref_regs_chk import sysref_status_pkg::*; (
    input wire logic core_clk, rst_b, reg_wr, reg_rd, synth_lol, sysref_phase_align, sysref_powered,
    input wire logic sysref_bias_xpoint,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata, reg_rdata,
    input wire logic [1:0] selected_input_status,
    input wire logic [3:0] input_power_down,
    input wire logic [5:0] sysref_sync_code
);
    logic src_reg;
    // Shadow source bit, written on the edge that takes the write.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) src_reg <= 1'b0;
        else if (reg_wr && reg_addr == ADDR_SR_MODE) src_reg <= reg_wdata[BIT_SRC];
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence start_wr; reg_wr && reg_addr == ADDR_START && reg_wdata[BIT_START]; endsequence
    sequence pwr_wr; reg_wr && reg_addr == ADDR_SR_PWR; endsequence
    pd_write_a: assert property (reg_wr && reg_addr == ADDR_INPUT_CTRL
        |=> input_power_down == $past(reg_wdata[5:2])) else $error("input power-down bits wrong");
    // The power byte is a register and these outputs are registered again, so they follow two edges later.
    sync_code_a: assert property (pwr_wr |=> ##1 sysref_sync_code == $past(reg_wdata[5:0], 2))
        else $error("release code wrong");
    bias_type_a: assert property (pwr_wr |=> ##1 sysref_bias_xpoint == $past(reg_wdata[BIT_BIAS], 2))
        else $error("bias type wrong");
    pd_sysref_a: assert property (pwr_wr ##0 reg_wdata[BIT_SR_PD] ##1 !(reg_wr && reg_addr == ADDR_START)
        |=> !sysref_powered) else $error("SYSREF still powered");
    start_take_a: assert property (start_wr ##0 !src_reg |=> sysref_phase_align && sysref_powered)
        else $error("start not taken");
    start_refuse_a: assert property (start_wr ##0 src_reg |=> !sysref_phase_align)
        else $error("start taken in external mode");
    align_cause_a: assert property (sysref_phase_align && !$past(src_reg)
        |-> $past(reg_wr && reg_addr == ADDR_START)) else $error("alignment without start");
    status_read_a: assert property (reg_rd && reg_addr == ADDR_ST_LOCK |=> reg_rdata[7:6] ==
        $past(selected_input_status) && reg_rdata[5] == !$past(synth_lol)) else $error("live status wrong");
endmodule
bind sysref_status_control_regs sysref_regs_chk sysref_regs_chk_inst (.*);

// *** test/host_port_model.sv ***
// Purpose: Host model driving the register port of the bank.
// Assumes: Strobes rise just after a rising edge and last one cycle.
// Notes: Idle write data shows the inverse of the last value.
`timescale 1ns/1ps
module host_port_model (
    input wire logic core_clk,
    input wire logic [7:0] reg_rdata,
    output logic [6:0] reg_addr = 7'h00,
    output logic [7:0] reg_wdata = 8'h00,
    output logic reg_wr = 1'b0, reg_rd = 1'b0
);
    task xfer(input logic w, input logic [6:0] a, input logic [7:0] v, output logic [7:0] r);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_wdata <= ~v;
        @(posedge core_clk);
        r = reg_rdata;
    endtask
endmodule

// *** test/tb_sysref_status_control_regs.sv ***
// Purpose: Self-checking bench for the SYSREF control and status bank.
// Assumes: The host model owns the register port; clk_en is held high.
// Notes: Status inputs come from one drive word d, set per table row.
`timescale 1ns/1ps
module tb_sysref_status_control_regs;
    import sysref_status_pkg::*;
    logic core_clk = 0, rst_b = 0, clk_en = 1, irq_out_n, sysref_pulse, reg_wr, reg_rd, lock;
    logic [26:0] d = 27'h0410;
    logic [7:0] r, steps, reg_wdata, reg_rdata;
    logic [6:0] reg_addr;
    logic [3:0] eff, flags;
    int errors = 0, samples_checked = 0;
    logic [41:0] rows [10] = '{{27'h0410, 7'h17, 8'h82}, {27'h0410, 7'h19, 8'h51}, {27'h0410, 7'h1A, 8'h02},
        {27'h0410, 7'h70, 8'h00}, {27'h0410, 7'h7F, 8'h00}, {27'h0412, 7'h6D, 8'hBF}, {27'h0415, 7'h6D, 8'h5F},
        {27'h0400, 7'h6D, 8'h2F}, {27'h0450, 7'h6F, 8'h07}, {27'h0450, 7'h6E, 8'h01}};
    host_port_model host_port_model_inst (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
    sysref_status_control_regs sysref_status_control_regs_inst (.core_clk(core_clk), .rst_b(rst_b),
        .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(), .input_los_event(d[18:15]), .input_period_valid(d[22:19]),
        .input_edge_missing(d[26:23]), .selected_input_status(d[1:0]), .synth_lol(d[2]), .osc_loop_lol(d[3]),
        .reference_present(d[4]), .holdover_active(d[5]), .synth_calibrating(d[6]), .coincident_edge(d[7]),
        .external_sysref_pin(d[8]), .clk3_sysref_in(d[9]), .output_bias_request_n(d[10]), .osc_out_power(d[11]),
        .osc_out_style(d[12]), .osc_out_amplitude(d[14:13]), .input_power_down(), .input_los_flag(flags),
        .holdoff_tick(), .lock_out(lock), .irq_out_n(irq_out_n), .sysref_powered(), .sysref_pulse(sysref_pulse),
        .sysref_bias_xpoint(), .sysref_bias_active(), .sysref_phase_align(), .sysref_delay_steps(steps),
        .sysref_sync_code(), .osc_eff_power(eff[3]), .osc_eff_style(eff[2]), .osc_eff_amplitude(eff[1:0]));
    // Free-running 100 MHz clock.
    initial forever #5 core_clk = ~core_clk;
    task chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h, want %h", $time, got, exp);
        end
    endtask
    task wr(input logic [6:0] a, input logic [7:0] v);
        host_port_model_inst.xfer(1'b1, a, v, r);
    endtask
    // Pulses are counted at falling edges over a window longer than any burst; pin is the external trigger.
    task run(input logic [7:0] mode, input logic [7:0] n, input logic pin);
        int p;
        p = 0;
        wr(ADDR_SR_MODE, mode);
        wr(ADDR_START, 8'h80);
        d[8] <= pin;
        repeat (400) begin
            @(negedge core_clk);
            if (sysref_pulse === 1'b1) p++;
        end
        chk(8'(p), n);
    endtask
    task give_verdict;
        if (errors == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Watchdog: the whole sequence needs about a seventh of this span.
    initial begin
        #100us;
        errors++;
        give_verdict;
    end
    // Reset, table rows, then interrupt, pulse and key cases.
    initial begin
        repeat (20) @(posedge core_clk);
        rst_b <= 1'b1;
        foreach (rows[i]) begin
            d <= rows[i][41:15];
            repeat (3) @(posedge core_clk);
            host_port_model_inst.xfer(1'b0, rows[i][14:8], 8'h00, r);
            chk(r, rows[i][7:0]);
        end
        chk({7'h00, irq_out_n}, 8'h01);
        wr(ADDR_IE_LOCK, 8'h20);
        repeat (2) @(posedge core_clk);
        chk({7'h00, irq_out_n}, 8'h00);
        wr(ADDR_LS_LOCK, 8'hFF);
        host_port_model_inst.xfer(1'b0, ADDR_LS_LOCK, 8'h00, r);
        chk(r, 8'h3F);
        chk({7'h00, irq_out_n}, 8'h01);
        d <= 27'h0490;
        wr(ADDR_SR_PWR, 8'h82);
        wr(ADDR_SR_DELAY, 8'h05);
        wr(ADDR_SR_COUNT, 8'h03);
        run(8'h00, 8'h03, 1'b0);
        chk(steps, 8'h05);
        run(8'h02, 8'h00, 1'b0);
        run(8'h02, 8'h03, 1'b1);
        chk({4'h0, eff}, 8'h0F);
        wr(ADDR_SR_MODE, 8'h40);
        wr(ADDR_LOCK_CTRL, 8'h0B);
        repeat (2) @(posedge core_clk);
        chk({4'h0, eff}, 8'h00);
        // Reference loss drops the lock pin until the block bit hides it.
        d[4] <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk({7'h00, lock}, 8'h00);
        wr(ADDR_SEL_MODE, 8'h40);
        repeat (2) @(posedge core_clk);
        chk({7'h00, lock}, 8'h01);
        // Input 0 re-validates after eight valid periods; powered-down input 3 ignores its loss event.
        wr(ADDR_INPUT_CTRL, 8'h20);
        d[18:15] <= 4'h9;
        @(posedge core_clk);
        d[22:15] <= 8'hF0;
        repeat (7) @(posedge core_clk);
        @(negedge core_clk);
        chk({4'h0, flags}, 8'h01);
        @(negedge core_clk);
        chk({4'h0, flags}, 8'h00);
        host_port_model_inst.xfer(1'b0, ADDR_LS_LOCK, 8'h00, r);
        chk(r, 8'h2E);
        give_verdict;
    end
endmodule
